// *** inc/crg_pkg.sv ***
// Shared constants and types of the clock, reset and processor glue block
`default_nettype none
package crg_pkg;
  // Coprocessor reset width in processor clocks, and its count in clk_i
  localparam int unsigned NPX_RST_PROC_CLKS = 96;
  localparam int unsigned DBL_PER_PROC      = 2;
  localparam logic [7:0]  NPX_RST_CYCLES    =
    8'(NPX_RST_PROC_CLKS * DBL_PER_PROC);
  // Timer clock is the oscillator divided by twelve (about 1.19 MHz)
  localparam int unsigned TIMER_OSC_DIV     = 12;
  localparam logic [2:0]  TIMER_HALF_EDGES  = 3'(TIMER_OSC_DIV / 2);
  // Refresh address reset value and the level of the upper lines
  localparam logic [9:0]  REFRESH_ADDR_RST  = 10'h000;
  localparam logic [11:0] REFRESH_HIGH_ADDR = 12'h000;
  // Coprocessor reset port: word address and byte enables (odd byte)
  localparam logic [5:0]  NPX_PORT_WORD     = 6'h3C;
  localparam logic [1:0]  NPX_PORT_BE_N     = 2'h1;
  // Positions of the pin inputs inside the synchroniser bank
  localparam int unsigned SYNC_W            = 8;
  localparam int unsigned SY_OSC            = 0;
  localparam int unsigned SY_ATCLK          = 1;
  localparam int unsigned SY_POWER_GOOD_IN          = 2;
  localparam int unsigned SY_KBC_RST_N      = 3;
  localparam int unsigned SY_PERR0_N        = 4;
  localparam int unsigned SY_PERR1_N        = 5;
  localparam int unsigned SY_CHCK_N         = 6;
  localparam int unsigned SY_NPX_REQ        = 7;
  // Idle levels of the synchronised pins while reset holds
  localparam logic [7:0]  SYNC_RST_VAL      = 8'h78;

  // Decoded processor cycle
  typedef struct packed {
    logic start;      // One-cycle pulse at the start of a bus cycle
    logic mem;        // Memory cycle when high, I/O when low
    logic write;      // Write cycle
    logic data_ctrl;  // Data (high) or control (low) status
  } crg_cycle_t;

  // Bus cycle tracking states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'h1,
    ST_LATCH = 3'h2,
    ST_PIPE  = 3'h4
  } crg_bus_state_t;
endpackage : crg_pkg
`default_nettype wire

// *** src/crg_sync.sv ***
// Bank of two-flop synchronisers for asynchronous pin inputs
`timescale 1ns/1ps
`default_nettype none
module crg_sync #(
  parameter int unsigned      WIDTH   = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_i,    // Double clock
  input  wire logic             rst_b_i,  // Asynchronous reset, low
  input  wire logic [WIDTH-1:0] async_i,  // Raw pin levels
  output logic      [WIDTH-1:0] sync_o    // Levels after two flops
);
  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_reg;

  // One pair of flops per bit
  genvar g;
  for (g = 0; g < WIDTH; g++) begin : g_bit
    always_ff @(posedge clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
        meta_reg[g] <= RST_VAL[g];
        sync_o[g]   <= RST_VAL[g];
      end else begin
        meta_reg[g] <= async_i[g];
        sync_o[g]   <= meta_reg[g];
      end
    end
  end
endmodule : crg_sync
`default_nettype wire

// *** src/crg_glue.sv ***
// Clock, reset and processor-interface glue of the system controller
`timescale 1ns/1ps
`default_nettype none
module crg_glue (
  input  wire logic               clk_i,                  // Double clock in
  input  wire logic               rst_b_i,                // Async reset
  input  wire logic               osc_clock_in_i,         // Oscillator pin
  input  wire logic               async_bus_clock_in_i,   // Async bus clk
  input  wire logic               sync_mode_i,            // 1: sync bus
  input  wire logic               power_good_in_i,        // Power good
  input  wire logic               kbc_reset_request_n_i,  // Keyboard reset
  input  wire logic               fast_reset_i,           // Port fast reset
  input  wire logic               parity_error_n_i0,      // Parity, byte 0
  input  wire logic               parity_error_n_i1,      // Parity, byte 1
  input  wire logic               channel_check_n_i,      // ISA check
  input  wire logic               npx_ext_request_in_i,   // Coproc request
  input  wire logic               addr_strobe_n_i,        // Address strobe
  input  wire logic               mem_io_select_i,        // Memory / I/O
  input  wire logic               write_i,                // Write status
  input  wire logic               data_ctrl_status_i,     // Data / control
  input  wire logic [1:0]         byte_en_n_i,            // Byte enables
  input  wire logic [23:2]        addr_i,                 // Address pins in
  input  wire logic               refresh_i,              // Refresh cycle
  input  wire logic               bus_master_i,           // ISA master
  input  wire logic               master_addr20_i,        // Master addr 20
  input  wire logic               proc_addr20_io_i,       // A20 pin in
  input  wire logic               addr20_gate_in_i,       // A20 gate
  output logic                    double_clock_out_o,     // Double clock
  output logic                    proc_clock_out_o,       // Processor clk
  output logic                    bus_clock_out_o,        // Bus clock
  output logic                    kbc_clock_out_o,        // Keyboard clk
  output logic                    timer_clock_out_o,      // Timer clock
  output logic                    proc_reset_out_o,       // CPU reset
  output logic                    npx_reset_out_o,        // Coproc reset
  output logic                    device_reset_n_o,       // Device reset
  output logic [23:2]             addr_o,                 // Address out
  output logic                    addr_oe_o,              // Address enable
  output logic                    proc_addr20_io_o,       // A20 pin out
  output logic                    proc_addr20_io_oe_o,    // A20 pin enable
  output logic                    gated_addr20_o,         // Gated A20 pin
  output logic                    int_addr20_o,           // Internal A20
  output logic                    proc_nmi_out_o,         // NMI
  output logic                    proc_ext_request_out_o, // Ext request
  output logic                    next_addr_n_o,          // Next address
  output logic                    early_addr_latch_en_o,  // Early ALE
  output crg_pkg::crg_cycle_t     cycle_o                 // Cycle decode
);

  // Returns high when an access hits the coprocessor reset port
  function automatic logic npx_port_hit(input logic [7:2] a,
                                        input logic [1:0] be_n);
    npx_port_hit = (a == crg_pkg::NPX_PORT_WORD) &&
                   (be_n == crg_pkg::NPX_PORT_BE_N);
  endfunction : npx_port_hit

  // Synchronised pin levels
  logic [crg_pkg::SYNC_W-1:0] pin_raw;      // Raw pin bundle
  logic [crg_pkg::SYNC_W-1:0] pin_s;        // After two flops
  logic                       osc_d_reg;    // Delayed oscillator level
  logic                       atclk_d_reg;  // Delayed async bus clock
  logic                       osc_rise;     // Oscillator rising edge
  logic                       atclk_rise;   // Async bus clock rise
  logic                       pwr_good;     // Power good, synchronised

  // Clock generators
  logic       proc_clk_reg;    // Processor clock phase
  logic       sync_bus_reg;    // Synchronous bus clock
  logic       async_bus_reg;   // Asynchronous bus clock
  logic       bus_aligned_reg; // Bus clock aligned to first strobe
  logic       kbc_clk_reg;     // Keyboard clock
  logic       timer_clk_reg;   // Timer clock
  logic [2:0] timer_cnt_reg;   // Oscillator edges in timer half period
  logic       proc_end;        // Last clk_i of a processor clock

  // Reset logic
  logic       reset_src;        // Any processor reset source
  logic       reset_src_d_reg;  // Previous reset_src
  logic       port_wr;          // Write to coprocessor reset port
  logic       npx_trigger;      // Start or restart of coprocessor reset
  logic [7:0] npx_cnt_reg;      // Remaining coprocessor reset cycles

  // Bus cycle tracking
  crg_pkg::crg_bus_state_t state_reg;   // Current state
  crg_pkg::crg_bus_state_t state_next;  // Next state
  logic                    cyc_start;   // Address strobe seen
  logic                    was_refresh_reg; // Refresh in previous cycle
  logic [9:0]              refresh_addr_reg; // Refresh row counter

  // Gather the asynchronous pins into one bank
  always_comb begin
    pin_raw                            = '0;
    pin_raw[crg_pkg::SY_OSC]           = osc_clock_in_i;
    pin_raw[crg_pkg::SY_ATCLK]         = async_bus_clock_in_i;
    pin_raw[crg_pkg::SY_POWER_GOOD_IN]         = power_good_in_i;
    pin_raw[crg_pkg::SY_KBC_RST_N]     = kbc_reset_request_n_i;
    pin_raw[crg_pkg::SY_PERR0_N]       = parity_error_n_i0;
    pin_raw[crg_pkg::SY_PERR1_N]       = parity_error_n_i1;
    pin_raw[crg_pkg::SY_CHCK_N]        = channel_check_n_i;
    pin_raw[crg_pkg::SY_NPX_REQ]       = npx_ext_request_in_i;
  end

  // Two flops on every pin that is not on the double clock
  crg_sync #(
    .WIDTH   (crg_pkg::SYNC_W),
    .RST_VAL (crg_pkg::SYNC_RST_VAL)
  ) u_sync (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .async_i (pin_raw),
    .sync_o  (pin_s)
  );

  assign pwr_good = pin_s[crg_pkg::SY_POWER_GOOD_IN];

  // Edge detectors look only at synchronised levels
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      osc_d_reg   <= 1'b0;
      atclk_d_reg <= 1'b0;
    end else begin
      osc_d_reg   <= pin_s[crg_pkg::SY_OSC];
      atclk_d_reg <= pin_s[crg_pkg::SY_ATCLK];
    end
  end

  assign osc_rise   = pin_s[crg_pkg::SY_OSC] & ~osc_d_reg;
  assign atclk_rise = pin_s[crg_pkg::SY_ATCLK] & ~atclk_d_reg;

  // The double clock input is forwarded to the processor unchanged
  assign double_clock_out_o = clk_i;

  // Processor clock: toggle every double clock, low out of reset so
  // that its phase matches the processor after the shared reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      proc_clk_reg <= 1'b0;
    end else begin
      proc_clk_reg <= ~proc_clk_reg;
    end
  end

  // Enable pulse on the second half of each processor clock
  assign proc_end         = proc_clk_reg;
  assign proc_clock_out_o = proc_clk_reg;

  // Synchronous bus clock: processor clock halved; re-phased once on
  // the first address strobe so later cycles start on a rising edge.
  // Re-phasing only once keeps the clock free-running afterwards.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sync_bus_reg    <= 1'b0;
      bus_aligned_reg <= 1'b0;
    end else if (cyc_start && !bus_aligned_reg) begin
      sync_bus_reg    <= 1'b0;
      bus_aligned_reg <= 1'b1;
    end else if (proc_end) begin
      sync_bus_reg    <= ~sync_bus_reg;
    end
  end

  // Asynchronous bus clock: each rising input edge toggles the output
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      async_bus_reg <= 1'b0;
    end else if (atclk_rise) begin
      async_bus_reg <= ~async_bus_reg;
    end
  end

  // Output register picks the source chosen by the bus mode
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bus_clock_out_o <= 1'b0;
    end else begin
      bus_clock_out_o <= sync_mode_i ? sync_bus_reg
                                     : async_bus_reg;
    end
  end

  // Keyboard clock: oscillator halved. Sampling a 14.3 MHz input at
  // 20 MHz loses edges, so the rate is only as good as the sampling.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      kbc_clk_reg <= 1'b0;
    end else if (osc_rise) begin
      kbc_clk_reg <= ~kbc_clk_reg;
    end
  end

  assign kbc_clock_out_o = kbc_clk_reg;

  // Timer clock: toggle every six oscillator edges, twelve per period
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      timer_cnt_reg <= 3'h0;
      timer_clk_reg <= 1'b0;
    end else if (osc_rise) begin
      if (timer_cnt_reg == crg_pkg::TIMER_HALF_EDGES - 3'h1) begin
        timer_cnt_reg <= 3'h0;
        timer_clk_reg <= ~timer_clk_reg;
      end else begin
        timer_cnt_reg <= timer_cnt_reg + 3'h1;
      end
    end
  end

  assign timer_clock_out_o = timer_clk_reg;

  // Any reset source; power good low keeps it up for its whole span
  assign reset_src = ~pwr_good
                   | ~pin_s[crg_pkg::SY_KBC_RST_N]
                   | fast_reset_i;

  // Processor and device resets, registered from their sources
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      proc_reset_out_o <= 1'b1;
      device_reset_n_o <= 1'b0;
      reset_src_d_reg  <= 1'b1;
    end else begin
      proc_reset_out_o <= reset_src;
      device_reset_n_o <= pwr_good;
      reset_src_d_reg  <= reset_src;
    end
  end

  // I/O write to the coprocessor reset port at cycle start
  assign port_wr = cyc_start && !mem_io_select_i && write_i &&
                   npx_port_hit(addr_i[7:2], byte_en_n_i);

  // A rise of reset_src, a port write or power still low reloads the
  // count; a keyboard or fast reset rising while another holds reset_src gives no reload
  assign npx_trigger = (reset_src && !reset_src_d_reg) || port_wr ||
                       !pwr_good;

  // Coprocessor reset counter, 96 processor clocks of double clock
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      npx_cnt_reg <= crg_pkg::NPX_RST_CYCLES;
    end else if (npx_trigger) begin
      npx_cnt_reg <= crg_pkg::NPX_RST_CYCLES;
    end else if (npx_cnt_reg != 8'h00) begin
      npx_cnt_reg <= npx_cnt_reg - 8'h01;
    end
  end

  // Output register decodes the next count, so it is high exactly while the count is non-zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      npx_reset_out_o <= 1'b1;
    end else begin
      npx_reset_out_o <= npx_trigger || (npx_cnt_reg > 8'h01);
    end
  end

  // Refresh row counter advances when a refresh cycle ends
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      was_refresh_reg  <= 1'b0;
      refresh_addr_reg <= crg_pkg::REFRESH_ADDR_RST;
    end else begin
      was_refresh_reg <= refresh_i;
      if (was_refresh_reg && !refresh_i) begin
        refresh_addr_reg <= refresh_addr_reg + 10'h001;
      end
    end
  end

  // Address pins: driven only in refresh, with the row counter and zeros above
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_o    <= '0;
      addr_oe_o <= 1'b0;
    end else begin
      addr_oe_o <= refresh_i;
      addr_o    <= {crg_pkg::REFRESH_HIGH_ADDR,
                    refresh_addr_reg};
    end
  end

  // Address 20: gating, gated pin and bus-master drive
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      int_addr20_o        <= 1'b0;
      gated_addr20_o      <= 1'b0;
      proc_addr20_io_o    <= 1'b0;
      proc_addr20_io_oe_o <= 1'b0;
    end else begin
      // A master sources bit 20 itself; otherwise the processor does
      if (bus_master_i) begin
        int_addr20_o   <= master_addr20_i & addr20_gate_in_i;
        gated_addr20_o <= master_addr20_i & addr20_gate_in_i;
      end else begin
        int_addr20_o   <= proc_addr20_io_i & addr20_gate_in_i;
        gated_addr20_o <= proc_addr20_io_i & addr20_gate_in_i;
      end
      proc_addr20_io_oe_o <= bus_master_i;
      proc_addr20_io_o    <= master_addr20_i;
    end
  end

  // NMI and extension request follow their synchronised sources
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      proc_nmi_out_o         <= 1'b0;
      proc_ext_request_out_o <= 1'b0;
    end else begin
      proc_nmi_out_o <= ~pin_s[crg_pkg::SY_PERR0_N]
                      | ~pin_s[crg_pkg::SY_PERR1_N]
                      | ~pin_s[crg_pkg::SY_CHCK_N];
      // Drops three double clocks after the coprocessor drops it on an empty FIFO
      proc_ext_request_out_o <= pin_s[crg_pkg::SY_NPX_REQ];
    end
  end

  // A strobe seen in the second half of a processor clock starts a
  // cycle; the strobe is on the double clock so needs no flops
  assign cyc_start = !addr_strobe_n_i && proc_end &&
                     (state_reg == crg_pkg::ST_IDLE);

  // Cycle decode latched at the start of each bus cycle
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      cycle_o <= '0;
    end else begin
      cycle_o.start <= cyc_start;
      if (cyc_start) begin
        cycle_o.mem       <= mem_io_select_i;
        cycle_o.write     <= write_i;
        cycle_o.data_ctrl <= data_ctrl_status_i;
      end
    end
  end

  // Cycle tracker: one processor clock of latch enable, then one of
  // next-address request; a strobe is taken only once back in idle
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      crg_pkg::ST_IDLE: begin
        if (cyc_start) begin
          state_next = crg_pkg::ST_LATCH;
        end
      end
      crg_pkg::ST_LATCH: begin
        if (proc_end) begin
          state_next = crg_pkg::ST_PIPE;
        end
      end
      crg_pkg::ST_PIPE: begin
        if (proc_end) begin
          state_next = crg_pkg::ST_IDLE;
        end
      end
      default: begin
        state_next = crg_pkg::ST_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= crg_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // Latch enable and next-address request come from the state
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      early_addr_latch_en_o <= 1'b0;
      next_addr_n_o         <= 1'b1;
    end else begin
      early_addr_latch_en_o <= (state_next == crg_pkg::ST_LATCH);
      next_addr_n_o         <= (state_next != crg_pkg::ST_PIPE);
    end
  end

endmodule : crg_glue
`default_nettype wire

// *** dv/crg_glue_assertions.sv ***
// Port checker of the clock, reset and processor glue block
`timescale 1ns/1ps
`default_nettype none
module crg_glue_chk (
  input wire logic        clk_i,
  input wire logic        rst_b_i,
  input wire logic        fast_reset_i,
  input wire logic        power_good_in_i,
  input wire logic        refresh_i,
  input wire logic        bus_master_i,
  input wire logic        proc_addr20_io_i,
  input wire logic        addr20_gate_in_i,
  input wire logic        parity_error_n_i0,
  input wire logic        npx_ext_request_in_i,
  input wire logic        addr_strobe_n_i,
  input wire logic        proc_clock_out_o,
  input wire logic        proc_reset_out_o,
  input wire logic        npx_reset_out_o,
  input wire logic        device_reset_n_o,
  input wire logic [23:2] addr_o,
  input wire logic        addr_oe_o,
  input wire logic        int_addr20_o,
  input wire logic        proc_nmi_out_o,
  input wire logic        proc_ext_request_out_o,
  input wire logic        next_addr_n_o,
  input wire logic        early_addr_latch_en_o,
  input wire crg_pkg::crg_cycle_t cycle_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  // Cycles the coprocessor reset has stood high; saturates, no wrap
  logic [7:0] npx_run_reg;
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) npx_run_reg <= 8'h00;
    else npx_run_reg <= !npx_reset_out_o ? 8'h00 :
      (npx_run_reg == 8'hFF ? 8'hFF : npx_run_reg + 8'h01);
  end
  a_proc_clk_run: assert property ($past(rst_b_i) |->
    proc_clock_out_o != $past(proc_clock_out_o)) else $error("clock stuck");
  a_fast_rst_hold: assert property (fast_reset_i [*2] |->
    proc_reset_out_o && npx_reset_out_o) else $error("fast reset lost");
  a_pg_low_hold: assert property (!power_good_in_i [*4] |->
    proc_reset_out_o && npx_reset_out_o && !device_reset_n_o)
    else $error("reset dropped while power is bad");
  a_npx_width: assert property ($fell(npx_reset_out_o) |->
    npx_run_reg >= 8'd190) else $error("coprocessor reset too short");
  a_refresh_drive: assert property ($past(rst_b_i) |->
    addr_oe_o == $past(refresh_i) && (!addr_oe_o || addr_o[23:12] == 12'h000))
    else $error("refresh address drive wrong");
  a_a20_gating: assert property ($past(rst_b_i) &&
    !$past(bus_master_i) |-> int_addr20_o == ($past(addr20_gate_in_i) &
    $past(proc_addr20_io_i))) else $error("internal address 20 wrong");
  a_nmi_parity: assert property (!parity_error_n_i0 [*5] |->
    proc_nmi_out_o) else $error("no NMI on parity error");
  a_ext_follow: assert property ($stable(npx_ext_request_in_i) [*5]
    |-> proc_ext_request_out_o == npx_ext_request_in_i)
    else $error("ext req wrong");
  a_cycle_steps: assert property (cycle_o.start |->
    early_addr_latch_en_o && next_addr_n_o ##1 early_addr_latch_en_o
    ##1 !early_addr_latch_en_o && !next_addr_n_o ##1 !next_addr_n_o
    ##1 next_addr_n_o) else $error("latch or next address timing");
  a_cycle_start: assert property (cycle_o.start |->
    !$past(addr_strobe_n_i) && $past(proc_clock_out_o))
    else $error("cycle start without strobe");
  c_io_cycle: cover property (cycle_o.start && !cycle_o.mem);
  c_npx_end: cover property ($fell(npx_reset_out_o));
  c_refresh: cover property (addr_oe_o);
endmodule : crg_glue_chk
bind crg_glue crg_glue_chk u_chk (.*);
`default_nettype wire

// *** dv/crg_proc_model.sv ***
// Behavioural processor on the local bus of the glue block
`timescale 1ns/1ps
`default_nettype none
module crg_proc_model (
  input  wire logic        clk_i,      // Double clock
  input  wire logic        proc_clk_i, // Processor clock from the block
  input  wire logic        start_i,    // Cycle start from the block
  input  wire logic        go_i,       // Bench asks for one bus cycle
  input  wire logic [10:0] cmd_i,      // {mem, write, dc, be_n, a[7:2]}
  output logic             ads_n_o,    // Address strobe, active low
  output logic      [10:0] st_o,       // Status, enables and address
  output logic             busy_o      // Strobe still outstanding
);
  initial {ads_n_o, st_o, busy_o} = {1'b1, 11'h7FF, 1'b0};
  // Strobe only in the high processor phase, held until it is taken
  always @(negedge clk_i) begin
    if (busy_o && start_i) begin
      ads_n_o <= 1'b1;
      st_o <= ~st_o; // Released lines must not show a stale value
      busy_o <= 1'b0;
    end else if (!busy_o && go_i && proc_clk_i) begin
      ads_n_o <= 1'b0;
      st_o <= cmd_i; // Memory/IO high for memory, low for I/O
      busy_o <= 1'b1;
    end
  end
endmodule : crg_proc_model
`default_nettype wire

// *** dv/crg_glue_bench.sv ***
// Self-checking bench of the clock, reset and processor glue block
`timescale 1ns/1ps
`default_nettype none
module crg_glue_bench;
  logic                clk_i, rst_b_i, go, busy, ads_n;
  logic [10:0]         cmd, st;       // Bus request and model lines
  logic [12:0]         d;             // Level inputs of the scenarios
  wire  [16:0]         o;             // Single-bit outputs
  wire  [21:0]         a_o;           // Address outputs
  logic [1:0]          ph;            // Oscillator phase, period 4
  logic [2:0]          ph6;           // Async bus clock phase, period 6
  logic [3:0]          prv;           // Clock levels at the last edge
  logic [9:0]          run, wid;      // Coprocessor reset high time
  crg_pkg::crg_cycle_t cyc, last_cyc; // Decode and last start seen
  int                  err_count, checks;
  int                  tg [4];        // Toggles: proc, bus, kbc, timer
  crg_glue u_dut (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .sync_mode_i(d[0]),
    .osc_clock_in_i(ph[1]), .async_bus_clock_in_i(ph6 < 3'd3),
    .power_good_in_i(d[1]), .kbc_reset_request_n_i(d[2]),
    .fast_reset_i(d[3]), .parity_error_n_i0(d[4]),
    .parity_error_n_i1(d[5]), .channel_check_n_i(d[6]),
    .npx_ext_request_in_i(d[7]), .addr_strobe_n_i(ads_n),
    .mem_io_select_i(st[10]), .write_i(st[9]),
    .data_ctrl_status_i(st[8]), .byte_en_n_i(st[7:6]),
    .addr_i({16'h0000, st[5:0]}), .refresh_i(d[8]),
    .bus_master_i(d[9]), .master_addr20_i(d[10]),
    .proc_addr20_io_i(d[11]), .addr20_gate_in_i(d[12]),
    .double_clock_out_o(o[0]), .proc_clock_out_o(o[1]),
    .bus_clock_out_o(o[2]), .kbc_clock_out_o(o[3]),
    .timer_clock_out_o(o[4]), .proc_reset_out_o(o[5]),
    .npx_reset_out_o(o[6]), .device_reset_n_o(o[7]),
    .addr_o(a_o), .addr_oe_o(o[8]), .proc_addr20_io_o(o[9]),
    .proc_addr20_io_oe_o(o[10]), .gated_addr20_o(o[11]),
    .int_addr20_o(o[12]), .proc_nmi_out_o(o[13]),
    .proc_ext_request_out_o(o[14]), .next_addr_n_o(o[15]),
    .early_addr_latch_en_o(o[16]), .cycle_o(cyc));
  crg_proc_model u_cpu (.clk_i(clk_i), .proc_clk_i(o[1]),
    .start_i(cyc.start), .go_i(go), .cmd_i(cmd), .ads_n_o(ads_n),
    .st_o(st), .busy_o(busy));
  initial begin
    clk_i = 1'b0;
    forever #25 clk_i = ~clk_i;
  end
  // Slow oscillator and async clock, so no edge slips past clk_i
  always @(negedge clk_i) begin
    ph <= ph + 2'd1;
    ph6 <= (ph6 == 3'd5) ? 3'd0 : ph6 + 3'd1;
  end
  // Monitor: toggle counts, last decode, coprocessor reset width
  always @(posedge clk_i) begin
    for (int i = 0; i < 4; i++) if (o[i+1] !== prv[i]) tg[i]++;
    prv <= o[4:1];
    if (cyc.start === 1'b1) last_cyc <= cyc;
    run <= (o[6] === 1'b1) ? run + 10'd1 : 10'd0;
    if (o[6] === 1'b0 && run != 10'd0) wid <= run;
  end
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task give_verdict;
    $display("checks %0d errors %0d", checks, err_count);
    if (err_count == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  // One processor cycle, then wait out the pipelined phase
  task bus_cycle(input logic [10:0] c);
    @(posedge clk_i);
    cmd = c;
    go = 1'b1;
    for (int n = 0; n < 20 && busy !== 1'b1; n++) @(posedge clk_i);
    go = 1'b0;
    for (int n = 0; n < 20 && busy !== 1'b0; n++) @(posedge clk_i);
    repeat (5) @(negedge clk_i);
  endtask : bus_cycle
  task npx_low;
    for (int n = 0; n < 600 && o[6] !== 1'b0; n++) @(negedge clk_i);
    @(negedge clk_i);
  endtask : npx_low
  task t_bus;
    for (int k = 0; k < 8; k++) begin
      last_cyc = 4'h0;
      bus_cycle({k[2:0], 2'b11, 6'h10});
      check(last_cyc, {1'b1, k[2:0]});
    end
  endtask : t_bus
  task t_clocks(input logic m);
    d[0] = m;
    repeat (48) @(negedge clk_i);
    for (int i = 0; i < 4; i++) tg[i] = 0;
    repeat (192) @(negedge clk_i);
    check(tg[0], 192);
    check(tg[1], m ? 96 : 32);
    check(tg[2], 48);
    check(tg[3], 8);
    @(posedge clk_i);
    #1 check(o[0], 1'b1);
    @(negedge clk_i);
  endtask : t_clocks
  task t_resets;
    for (int s = 0; s < 3; s++) begin
      d[3:1] = {s == 0, s != 1, s != 2};
      repeat (8) @(negedge clk_i);
      check({o[5], o[6], o[7]}, {2'b11, s != 2});
      d[3:1] = 3'b011;
      repeat (8) @(negedge clk_i);
      check(o[5], 1'b0);
      npx_low;
      check(wid > 10'd189, 1'b1);
    end
  endtask : t_resets
  task t_npx_port;
    bus_cycle({3'b011, 2'b00, 6'h3C});
    check(o[6], 1'b0);
    bus_cycle({3'b011, 2'b01, 6'h3C});
    check(o[6], 1'b1);
    npx_low;
    check(wid > 10'd189 && wid < 10'd194, 1'b1);
    bus_cycle({3'b011, 2'b01, 6'h3C});
    repeat (100) @(negedge clk_i);
    d[3] = 1'b1;
    repeat (2) @(negedge clk_i);
    d[3] = 1'b0;
    npx_low;
    check(wid > 10'd280, 1'b1);
  endtask : t_npx_port
  task t_pins;
    d[12:8] = 5'b10111;
    repeat (2) @(negedge clk_i);
    check({o[8], a_o, o[10:9]}, {13'h1000, 10'h000, 2'b11});
    d[12:8] = 5'b01000;
    repeat (2) @(negedge clk_i);
    check({o[8], o[10], o[12], o[11]}, 4'h0);
    d[12] = 1'b1;
    repeat (2) @(negedge clk_i);
    check({o[12], o[11]}, 2'b11);
    for (int i = 4; i < 8; i++) begin
      d[i] = ~d[i];
      repeat (5) @(negedge clk_i);
      check(i < 7 ? o[13] : o[14], 1'b1);
      d[i] = ~d[i];
      repeat (5) @(negedge clk_i);
      check(i < 7 ? o[13] : o[14], 1'b0);
    end
  endtask : t_pins
  initial begin
    {rst_b_i, go, cmd, d} = {1'b0, 1'b0, 11'h000, 13'h1077};
    {ph, ph6, run, wid, prv, last_cyc} = {2'd0, 3'd0, 10'd0, 10'd0, 8'h00};
    repeat (15) @(negedge clk_i);
    check({o[5], o[6], o[7], o[8], o[15]}, 5'b11001);
    @(negedge clk_i);
    rst_b_i = 1'b1;
    npx_low;
    t_bus;
    t_clocks(1'b1);
    t_clocks(1'b0);
    d[0] = 1'b1;
    t_resets;
    t_npx_port;
    t_pins;
    give_verdict;
  end
  // About 1900 cycles are needed; 5000, over twice that, means a hang
  initial begin
    #250000;
    err_count++;
    give_verdict;
  end
endmodule : crg_glue_bench
`default_nettype wire
